// ---- sdc_sinc3_conv.sv ----
// Contract
// - Filter select bit at zero routes conversions through the sinc3 filter.
// - Low-latency selection gives settled data in one period, nothing suppressed.
// - Sinc3 output settles only after three complete conversion periods.
// - Magnitude response is the cubed sinc of the decimation ratio.
// - Response scales with data rate, zeros at every multiple of it.
// - At 2.5, 5, 10 SPS both 50 Hz and 60 Hz are rejected.
// - 16.6 and 50 SPS reject 50 Hz; 20 and 60 SPS reject 60 Hz.
// - Bandwidth near 0.26 of data rate, 2.6 Hz at 10 SPS.
// - Notches, bandwidth and rate scale with the converter clock.
// - First two sinc3 outputs after a start are discarded; low-latency mode discards none.
// - First settled result takes 307265 down to 232 modulator periods.
// - Continuous results after the first follow exactly one data period apart.
// - Programmable delay precedes sampling; default code gives 14 modulator periods.
// - First conversion is delay, then sampling, then overhead, then result.
// - Overhead applies offset and gain compensation to the filter result.
// - Suppressed outputs skip the overhead and are never readable.
// - Start pin rising edge or start command begins conversion timing.
// - Sequencing identical for both filters except sinc3 settling at third result; code also takes overhead length from a per-filter table.
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sdc_sinc3_conv (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic mod_clk_in,
   input wire logic mod_bit_in,
   input wire logic start_pin_in,
   input wire logic cmd_start_in,
   input wire logic [sdc_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [sdc_pkg::DATA_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [sdc_pkg::DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic data_ready_out,
   output logic busy_out
);
   import sdc_pkg::*;

   // ==========================================================
   // Helpers
   // ==========================================================
   // Byte-lane merge for partial writes
   function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] wd,
                                                  input logic [3:0] be);
      logic [DATA_W-1:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (be[b])
            r[b*8 +: 8] = wd[b*8 +: 8];
      return r;
   endfunction
   // Right shift that brings a sinc3 result to about 24 bits
   function automatic logic [5:0] norm_shift(input logic [PER_W-1:0] per);
      int lg;
      int sh;
      lg = 0;
      for (int i = 0; i < PER_W; i++)
         if (((per - 17'h00001) >> i) != '0)
            lg = i + 1;
      sh = int'(SINC_ORDER) * lg - int'(OUT_BITS);
      return (sh < 0) ? 6'h00 : 6'(sh);
   endfunction
   // Offset removal then Q2.15 gain
   function automatic logic [DATA_W-1:0] compensate(input logic [DATA_W-1:0] x,
                                                    input logic [DATA_W-1:0] off,
                                                    input logic [GAIN_W-1:0] g);
      logic signed [DATA_W:0] dif;
      logic signed [50:0] prod;
      dif = signed'({x[DATA_W-1], x}) - signed'({off[DATA_W-1], off});
      prod = 51'(dif) * 51'(signed'({1'b0, g}));
      return prod[GAIN_FRAC +: DATA_W];
   endfunction
   // ==========================================================
   // Pin synchronisers: modulator clock, modulator bit, start pin
   // ==========================================================
   logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d, hist_q, hist_d;
   logic tick, start_pin_rise;
   // Stage one feeds only stage two; the third flop is for edge detect
   always_comb
   begin
      sync1_d = {start_pin_in, mod_bit_in, mod_clk_in};
      sync2_d = sync1_q;
      hist_d = sync2_q;
   end
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         hist_q <= 3'h0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         hist_q <= hist_d;
      end
   end
   // Every count below is in modulator periods, so all timing scales with it
   assign tick = sync2_q[0] & ~hist_q[0];
   assign start_pin_rise = sync2_q[2] & ~hist_q[2];
   // ==========================================================
   // Register bus slave
   // ==========================================================
   logic ack_q, ack_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [DATA_W-1:0] rate_q, rate_d, dly_q, dly_d, off_q, off_d;
   logic [GAIN_W-1:0] gain_q, gain_d;
   logic [DATA_W-1:0] gain_word;
   logic rd_acc, wr_acc, cmd_start;
   logic ready_q, ready_d, publish;
   logic [DATA_W-1:0] result_q, result_d;
   sdc_seq_t st_q, st_d;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
   assign rd_acc = avs_read_in & ack_q;
   assign wr_acc = avs_write_in & ack_q;
   assign cmd_start = wr_acc && avs_address_in == ADDR_CMD
                      && avs_byteenable_in[0] && avs_writedata_in[CMD_START_BIT];
   assign gain_word = DATA_W'(gain_q);
   // One wait cycle per access; read data is captured during it
   always_comb
   begin
      ack_d = (avs_read_in | avs_write_in) & ~ack_q;
      rdata_d = rdata_q;
      rate_d = rate_q;
      dly_d = dly_q;
      off_d = off_q;
      gain_d = gain_q;
      if (avs_read_in && !ack_q)
      begin
         if (avs_address_in == ADDR_STATUS)
         begin
            rdata_d = '0;
            rdata_d[STAT_READY_BIT] = ready_q;
            rdata_d[STAT_BUSY_BIT] = (st_q != SEQ_IDLE);
         end
         else if (avs_address_in == ADDR_RATE) rdata_d = rate_q;
         else if (avs_address_in == ADDR_DELAY) rdata_d = dly_q;
         else if (avs_address_in == ADDR_DATA) rdata_d = result_q;
         else if (avs_address_in == ADDR_OFFSET) rdata_d = off_q;
         else if (avs_address_in == ADDR_GAIN) rdata_d = gain_word;
         else rdata_d = '0; // Unmapped and command reads return zero
      end
      if (wr_acc)
      begin
         if (avs_address_in == ADDR_RATE)
            rate_d = be_merge(rate_q, avs_writedata_in, avs_byteenable_in) & 32'h0000003F;
         else if (avs_address_in == ADDR_DELAY)
            dly_d = be_merge(dly_q, avs_writedata_in, avs_byteenable_in) & 32'h00000007;
         else if (avs_address_in == ADDR_OFFSET)
            off_d = be_merge(off_q, avs_writedata_in, avs_byteenable_in);
         else if (avs_address_in == ADDR_GAIN)
            gain_d = GAIN_W'(be_merge(gain_word, avs_writedata_in, avs_byteenable_in));
      end
      // New result wins over a concurrent read of the data register
      ready_d = ready_q;
      if (rd_acc && avs_address_in == ADDR_DATA) ready_d = 1'b0;
      if (publish) ready_d = 1'b1;
   end
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ack_q <= 1'b0;
         rdata_q <= '0;
         rate_q <= DATA_W'(RATE_RST);
         dly_q <= DATA_W'(DELAY_RST);
         off_q <= OFFSET_RST;
         gain_q <= GAIN_RST;
         ready_q <= 1'b0;
      end
      else
      begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         rate_q <= rate_d;
         dly_q <= dly_d;
         off_q <= off_d;
         gain_q <= gain_d;
         ready_q <= ready_d;
      end
   end
   assign avs_readdata_out = rdata_q;
   assign data_ready_out = ready_q;
   assign busy_out = (st_q != SEQ_IDLE);
   // ==========================================================
   // Filter datapath and conversion sequencer
   // ==========================================================
   logic signed [ACC_W-1:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q, e1_q;
   logic signed [ACC_W-1:0] i1_d, i2_d, i3_d, d1_d, d2_d, d3_d, e1_d;
   logic signed [ACC_W-1:0] x, c1, c2, c3, ll;
   logic [DATA_W-1:0] raw_q, raw_d, filt_out;
   logic [PER_W-1:0] cnt_q, cnt_d, per;
   logic [1:0] disc_q, disc_d;
   sdc_cfg_t run_q, run_d, cfg_now;
   logic start_ev, dec, sampling;
   // Either trigger starts timing; a start during a conversion restarts it
   assign start_ev = start_pin_rise | cmd_start_in | cmd_start;
   assign cfg_now = '{filt_ll: rate_q[FILT_BIT], single: rate_q[SINGLE_BIT],
                      rate: rate_q[RATE_LSB +: 4], dly: dly_q[DELAY_LSB +: 3]};
   // Decimation ratio per rate places notches at multiples of it
   assign per = period_of(run_q.rate);
   assign sampling = (st_q != SEQ_IDLE) && (st_q != SEQ_DELAY);
   assign dec = tick && (st_q == SEQ_SAMPLE || st_q == SEQ_STEADY)
                && cnt_q == per - 17'h00001;
   // Three integrators and three combs give the cubed sinc response
   always_comb
   begin
      x = sync2_q[1] ? ACC_W'(1) : -ACC_W'(1);
      c1 = i3_q - d1_q;
      c2 = c1 - d2_q;
      c3 = c2 - d3_q;
      ll = i1_q + x - e1_q; // One-period boxcar, current sample included
      // Filter select at zero takes the sinc3 path
      filt_out = run_q.filt_ll ? ll[DATA_W-1:0]
                               : DATA_W'(c3 >>> norm_shift(per));
      i1_d = i1_q;
      i2_d = i2_q;
      i3_d = i3_q;
      d1_d = d1_q;
      d2_d = d2_q;
      d3_d = d3_q;
      e1_d = e1_q;
      if (start_ev)
      begin
         i1_d = '0;
         i2_d = '0;
         i3_d = '0;
         d1_d = '0;
         d2_d = '0;
         d3_d = '0;
         e1_d = '0;
      end
      else if (tick && sampling)
      begin
         i1_d = i1_q + x;
         i2_d = i2_q + i1_q;
         i3_d = i3_q + i2_q;
         if (dec)
         begin
            d1_d = i3_q;
            d2_d = c1;
            d3_d = c2;
            e1_d = i1_d;
         end
      end
   end
   // Sequencer: delay, sampling periods, overhead, then steady periods, or idle in single-shot
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      disc_d = disc_q;
      run_d = run_q;
      raw_d = raw_q;
      result_d = result_q;
      publish = 1'b0;
      if (start_ev)
      begin
         st_d = SEQ_DELAY;
         cnt_d = '0;
         disc_d = '0;
         run_d = cfg_now;
      end
      else if (tick)
      begin
         case (st_q)
            SEQ_DELAY:
            begin
               // Start delay before any modulator sample is used
               if (cnt_q == delay_of(run_q.dly) - 17'h00001)
               begin
                  st_d = SEQ_SAMPLE;
                  cnt_d = '0;
               end
               else
                  cnt_d = cnt_q + 17'h00001;
            end
            SEQ_SAMPLE:
            begin
               if (dec)
               begin
                  cnt_d = '0;
                  // Unsettled sinc3 outputs are dropped with no overhead
                  if (!run_q.filt_ll && disc_q != SUPPRESS_CNT)
                     disc_d = disc_q + 2'h1;
                  else
                  begin
                     raw_d = filt_out;
                     st_d = SEQ_OVERHEAD;
                  end
               end
               else
                  cnt_d = cnt_q + 17'h00001;
            end
            SEQ_OVERHEAD:
            begin
               // Overhead length completes the first-result count
               if (cnt_q == PER_W'(run_q.filt_ll ? ll_ovh_of(run_q.rate)
                                                 : sinc3_ovh_of(run_q.rate)) - 17'h00001)
               begin
                  result_d = compensate(raw_q, off_q, gain_q);
                  publish = 1'b1;
                  cnt_d = '0;
                  st_d = run_q.single ? SEQ_IDLE : SEQ_STEADY;
               end
               else
                  cnt_d = cnt_q + 17'h00001;
            end
            SEQ_STEADY:
            begin
               // One result per data period, no delay added
               if (dec)
               begin
                  result_d = compensate(filt_out, off_q, gain_q);
                  publish = 1'b1;
                  cnt_d = '0;
               end
               else
                  cnt_d = cnt_q + 17'h00001;
            end
            default: cnt_d = '0; // Idle until the next start
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         i1_q <= '0;
         i2_q <= '0;
         i3_q <= '0;
         d1_q <= '0;
         d2_q <= '0;
         d3_q <= '0;
         e1_q <= '0;
         st_q <= SEQ_IDLE;
         cnt_q <= '0;
         disc_q <= '0;
         run_q <= '0;
         raw_q <= '0;
         result_q <= '0;
      end
      else
      begin
         i1_q <= i1_d;
         i2_q <= i2_d;
         i3_q <= i3_d;
         d1_q <= d1_d;
         d2_q <= d2_d;
         d3_q <= d3_d;
         e1_q <= e1_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         disc_q <= disc_d;
         run_q <= run_d;
         raw_q <= raw_d;
         result_q <= result_d;
      end
   end
endmodule // sdc_sinc3_conv
`default_nettype wire

// ---- sdc_pkg.sv ----
`default_nettype none
package sdc_pkg;
   // ==========================================================
   // Widths
   // ==========================================================
   localparam int unsigned PER_W = 17;
   localparam int unsigned OVH_W = 11;
   localparam int unsigned ACC_W = 52;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned GAIN_W = 17;
   localparam int unsigned GAIN_FRAC = 15;
   localparam int unsigned OUT_BITS = 24;
   localparam int unsigned SINC_ORDER = 3;
   localparam logic [1:0] SUPPRESS_CNT = 2'h2;

   // ==========================================================
   // Register byte addresses
   // ==========================================================
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_RATE = 5'h04;
   localparam logic [ADDR_W-1:0] ADDR_DELAY = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_CMD = 5'h0C;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET = 5'h14;
   localparam logic [ADDR_W-1:0] ADDR_GAIN = 5'h18;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int unsigned RATE_LSB = 0;
   localparam int unsigned FILT_BIT = 4;
   localparam int unsigned SINGLE_BIT = 5;
   localparam int unsigned DELAY_LSB = 0;
   localparam int unsigned CMD_START_BIT = 0;
   localparam int unsigned STAT_READY_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 1;
   localparam logic [3:0] RATE_RST = 4'h4;
   localparam logic [2:0] DELAY_RST = 3'h0;
   localparam logic [GAIN_W-1:0] GAIN_RST = 17'h08000;
   localparam logic [DATA_W-1:0] OFFSET_RST = 32'h00000000;

   // Configuration captured at each start
   typedef struct packed {
      logic filt_ll;
      logic single;
      logic [3:0] rate;
      logic [2:0] dly;
   } sdc_cfg_t;

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_DELAY,
      SEQ_SAMPLE,
      SEQ_OVERHEAD,
      SEQ_STEADY
   } sdc_seq_t;

   // Decimation ratio: modulator periods per data period, 2.5 SPS upward
   function automatic logic [PER_W-1:0] period_of(input logic [3:0] r);
      case (r)
         4'h0: return 17'h19000;
         4'h1: return 17'h0C800;
         4'h2: return 17'h06400;
         4'h3: return 17'h03C00;
         4'h4: return 17'h03200;
         4'h5: return 17'h01400;
         4'h6: return 17'h010A8;
         4'h7: return 17'h00A00;
         4'h8: return 17'h00500;
         4'h9: return 17'h00280;
         4'hA: return 17'h00140;
         4'hB: return 17'h00100;
         4'hC: return 17'h00080;
         default: return 17'h00040;
      endcase
   endfunction

   // Overhead after the third sinc3 period (65 up to 800 SPS, else 40)
   function automatic logic [OVH_W-1:0] sinc3_ovh_of(input logic [3:0] r);
      return (r <= 4'hA) ? 11'h041 : 11'h028;
   endfunction

   // Overhead after the single low-latency period
   function automatic logic [OVH_W-1:0] ll_ovh_of(input logic [3:0] r);
      case (r)
         4'h0, 4'h1, 4'h2, 4'h4: return 11'h681;
         4'h3, 4'h6: return 11'h041;
         default: return 11'h028;
      endcase
   endfunction

   // Programmable start delay in modulator periods
   function automatic logic [PER_W-1:0] delay_of(input logic [2:0] c);
      case (c)
         3'h0: return 17'h0000E;
         3'h1: return 17'h00019;
         3'h2: return 17'h00040;
         3'h3: return 17'h00100;
         3'h4: return 17'h00400;
         3'h5: return 17'h00800;
         3'h6: return 17'h01000;
         default: return 17'h00001;
      endcase
   endfunction
endpackage
`default_nettype wire

// ---- sdc_sinc3_conv_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_chk (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic mod_clk_in,
   input wire logic start_pin_in,
   input wire logic cmd_start_in,
   input wire logic [sdc_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [sdc_pkg::DATA_W-1:0] avs_writedata_in,
   input wire logic avs_waitrequest_out,
   input wire logic data_ready_out,
   input wire logic busy_out
);
   import sdc_pkg::*;
   // ==========================================
   // Ticks counted since the last start
   // ==========================================
   logic [2:0] mq_q, mq_d, pq_q, pq_d;
   logic [9:0] cnt_q, cnt_d;
   logic fst_q, fst_d, rdy_q, go;
   // Own two-flop sync, same depth as the design's, so the count keeps step with its ticks
   always_comb
   begin
      mq_d = {mq_q[1:0], mod_clk_in};
      pq_d = {pq_q[1:0], start_pin_in};
      go = cmd_start_in | (pq_q[1] & ~pq_q[2]) | (avs_write_in & ~avs_waitrequest_out
         & (avs_address_in == ADDR_CMD) & avs_writedata_in[0]);
      cnt_d = cnt_q + {9'h000, mq_q[1] & ~mq_q[2] & ~&cnt_q};
      if (go)
         cnt_d = 10'h000;
      fst_d = go | (fst_q & ~(data_ready_out & ~rdy_q));
   end
   // Registers only
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         mq_q <= 3'h0;
         pq_q <= 3'h0;
         cnt_q <= 10'h000;
         fst_q <= 1'b0;
         rdy_q <= 1'b0;
      end
      else
      begin
         mq_q <= mq_d;
         pq_q <= pq_d;
         cnt_q <= cnt_d;
         fst_q <= fst_d;
         rdy_q <= data_ready_out;
      end
   end
   // ==========================================
   // Properties
   // ==========================================
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   sequence s_start;
      go;
   endsequence
   sequence s_quiet;
      (!$rose(data_ready_out)) [*8];
   endsequence
   property p_wait_first;
      $rose(avs_read_in | avs_write_in) |-> avs_waitrequest_out;
   endproperty
   a_wait_first: assert property (p_wait_first)
      else $error("No wait state on a new request");
   property p_wait_once;
      (avs_read_in | avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
   endproperty
   a_wait_once: assert property (p_wait_once)
      else $error("Access not answered after one wait state");
   property p_cmd_busy;
      cmd_start_in |-> ##[1:2] busy_out;
   endproperty
   a_cmd_busy: assert property (p_cmd_busy)
      else $error("Start command did not start the sequencer");
   property p_pin_busy;
      $rose(start_pin_in) |-> ##[2:6] busy_out;
   endproperty
   a_pin_busy: assert property (p_pin_busy)
      else $error("Start pin edge did not start the sequencer");
   property p_quiet;
      s_start |=> s_quiet;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("Result appeared right after a start");
   property p_first_late;
      data_ready_out && !rdy_q && fst_q |-> cnt_q >= 10'h064;
   endproperty
   a_first_late: assert property (p_first_late)
      else $error("First result earlier than delay, period and overhead");
   property p_idle;
      $fell(busy_out) |-> data_ready_out;
   endproperty
   a_idle: assert property (p_idle)
      else $error("Sequencer went idle without a result");
   property p_clear;
      avs_read_in && !avs_waitrequest_out && avs_address_in == ADDR_DATA |=> !data_ready_out;
   endproperty
   a_clear: assert property (p_clear)
      else $error("Ready flag not cleared by a result read");
endmodule // sdc_chk
bind sdc_sinc3_conv sdc_chk u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
   .mod_clk_in(mod_clk_in), .start_pin_in(start_pin_in), .cmd_start_in(cmd_start_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
   .data_ready_out(data_ready_out), .busy_out(busy_out));
`default_nettype wire

// ---- sdc_mod_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_mod_model (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [1:0] pat_in,
   output logic mod_clk_out,
   output logic mod_bit_out
);
   // ==========================================
   // Free-running modulator: ones, zeros or alternating
   // ==========================================
   logic [2:0] div_q, div_d;
   logic clk_q, clk_d, bit_q, bit_d;
   // Five clocks a phase; bit moves on the fall so it is steady at each rise
   always_comb
   begin
      div_d = (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
      clk_d = (div_q == 3'h4) ? ~clk_q : clk_q;
      bit_d = bit_q;
      if (div_q == 3'h4 && clk_q)
         bit_d = (pat_in == 2'h0) | ((pat_in == 2'h2) & ~bit_q);
   end
   // Registers only
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         div_q <= 3'h0;
         clk_q <= 1'b0;
         bit_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         clk_q <= clk_d;
         bit_q <= bit_d;
      end
   end
   assign mod_clk_out = clk_q;
   assign mod_bit_out = bit_q;
endmodule // sdc_mod_model
`default_nettype wire

// ---- sdc_sinc3_conv_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_sinc3_conv_test;
   import sdc_pkg::*;
   // ==========================================
   // Design, modulator and clock
   // ==========================================
   logic clk_in, resetn_in, mclk, mbit, spin, cst, rd, wr, wreq, rdy, busy;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, v;
   logic [1:0] pat;
   logic [15:0] seed;
   logic [16:0] g;
   int fail_count, tests_run, tick_cnt, t0, off;
   sdc_sinc3_conv DUT (.clk_in(clk_in), .resetn_in(resetn_in), .mod_clk_in(mclk),
      .mod_bit_in(mbit), .start_pin_in(spin), .cmd_start_in(cst), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .data_ready_out(rdy), .busy_out(busy));
   sdc_mod_model u_mod (.clk_in(clk_in), .resetn_in(resetn_in), .pat_in(pat),
      .mod_clk_out(mclk), .mod_bit_out(mbit));
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Raw modulator ticks for timing expectations
   always @(posedge mclk) tick_cnt = tick_cnt + 1;
   // ==========================================
   // Helpers
   // ==========================================
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Ticks to the first result at rate index 13 (64-tick period, 40 overhead)
   function automatic int first_ticks(input logic ll, input logic [2:0] c);
      int d;
      d = (c == 3'h0) ? 14 : (c == 3'h2) ? 64 : 1;
      return d + (ll ? 64 + 40 : 3 * 64 + 40);
   endfunction
   function automatic logic [31:0] ll_res(input int sum, input int o, input int gn);
      longint r;
      r = (longint'(sum - o) * gn) >>> 15;
      return r[31:0];
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // One Avalon access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      wr <= w;
      rd <= ~w;
      addr <= a;
      wdata <= d;
      i = 0;
      do
      begin
         @(posedge clk_in);
         i++;
      end
      while (wreq !== 1'b0 && i < 50);
      v = rdata;
      if (i >= 50)
         chk("bus answer", 32'h0, 32'h1);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Start just after a modulator fall, so no tick is split by the sync
   task automatic start(input logic pin);
      while (mclk !== 1'b1) @(posedge clk_in);
      while (mclk !== 1'b0) @(posedge clk_in);
      if (pin)
         spin <= 1'b1;
      else
         cst <= 1'b1;
      t0 = tick_cnt;
      @(posedge clk_in);
      cst <= 1'b0;
      repeat (3) @(posedge clk_in);
      spin <= 1'b0;
   endtask
   task automatic wait_ready(input string what, input int exp);
      int i;
      i = 0;
      while (rdy !== 1'b1 && i < 20000)
      begin
         @(posedge clk_in);
         i++;
      end
      chk(what, exp, tick_cnt - t0);
      t0 = tick_cnt;
   endtask
   task automatic take();
      bus(1'b0, ADDR_DATA, 32'h0);
      @(posedge clk_in);
      chk("ready after read", 32'h0, {31'h0, rdy});
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog: the sequence needs about 16000 clocks
   initial
   begin
      repeat (100000) @(posedge clk_in);
      fail_count++;
      stop_test();
   end
   // ==========================================
   // Scenarios
   // ==========================================
   initial
   begin
      resetn_in = 1'b0;
      {rd, wr, cst, spin} = 4'h0;
      addr = 5'h00;
      wdata = 32'h0;
      pat = 2'h0;
      seed = 16'h000B;
      repeat (20) @(posedge clk_in);
      resetn_in <= 1'b1;
      // Reset values, read-only and unmapped places
      bus(1'b0, ADDR_RATE, 32'h0);
      chk("rate reset", 32'h00000004, v);
      bus(1'b0, ADDR_GAIN, 32'h0);
      chk("gain reset", 32'h00008000, v);
      bus(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status", 32'h0, v);
      bus(1'b1, 5'h1C, 32'hFFFFFFFF);
      bus(1'b0, 5'h1C, 32'h0);
      chk("unmapped", 32'h0, v);
      // Sinc3 continuous: two suppressed outputs, then one per period
      bus(1'b1, ADDR_RATE, 32'h0000000D);
      start(1'b0);
      wait_ready("sinc3 first", first_ticks(1'b0, 3'h0));
      take();
      repeat (2)
      begin
         wait_ready("steady period", 64);
         take();
      end
      // Start by register write, then restart by pin part way through
      bus(1'b1, ADDR_CMD, 32'h00000001);
      while (tick_cnt - t0 < 100) @(posedge clk_in);
      start(1'b1);
      wait_ready("restart", first_ticks(1'b0, 3'h0));
      take();
      // Sinc3 single-shot with a longer start delay
      bus(1'b1, ADDR_RATE, 32'h0000002D);
      bus(1'b1, ADDR_DELAY, 32'h00000002);
      start(1'b0);
      wait_ready("delayed first", first_ticks(1'b0, 3'h2));
      take();
      while (tick_cnt - t0 < 200) @(posedge clk_in);
      chk("single stays idle", 32'h0, {30'h0, rdy, busy});
      // Low-latency single-shot with random offset and gain
      for (int k = 0; k < 3; k++)
      begin
         seed = lfsr(seed);
         off = int'(seed[9:0]) - 512;
         seed = lfsr(seed);
         g = {seed, seed[0]};
         pat <= k[1:0];
         bus(1'b1, ADDR_OFFSET, 32'(off));
         bus(1'b1, ADDR_GAIN, {15'h0, g});
         bus(1'b1, ADDR_RATE, 32'h0000003D);
         bus(1'b1, ADDR_DELAY, 32'h00000007);
         start(1'b0);
         wait_ready("low latency first", first_ticks(1'b1, 3'h7));
         bus(1'b0, ADDR_DATA, 32'h0);
         chk("result", ll_res((k == 0) ? 64 : (k == 1) ? -64 : 0, off, int'(g)), v);
         chk("idle after result", 32'h0, {31'h0, busy});
      end
      stop_test();
   end
endmodule // sdc_sinc3_conv_test
`default_nettype wire
